// ### design/pmc_pkg.sv
// Package for the power mode controller: register map, mode codes, timing counts.
// Assumes a 10 MHz system clock and a plain strobe register port.
package pmc_pkg;

   typedef enum logic [1:0] {
      PMC_MODE_RUN   = 2'h0,
      PMC_MODE_SLEEP = 2'h1,
      PMC_MODE_DEEP  = 2'h2,
      PMC_MODE_COMA  = 2'h3
   } pmc_mode_t;

   // Register offsets
   localparam logic [3:0] PMC_OFF_CTRL   = 4'h0;
   localparam logic [3:0] PMC_OFF_FLASH  = 4'h4;
   localparam logic [3:0] PMC_OFF_STATUS = 4'h8;

   // Field positions
   localparam int PMC_CTRL_MODE_LSB = 0;
   localparam int PMC_CTRL_RETA_BIT = 2;
   localparam int PMC_CTRL_RETB_BIT = 3;
   localparam int PMC_STAT_DBG_BIT  = 4;
   localparam int PMC_STAT_STL_BIT  = 5;

   // Reset values
   localparam logic [1:0] PMC_RST_MODE  = 2'h0;
   localparam logic       PMC_RST_RET   = 1'b1;
   localparam logic [1:0] PMC_RST_FLASH = 2'h3;

   // Flash power-up settle time
   localparam int PMC_CLK_HZ        = 10_000_000;
   localparam int PMC_FLASH_UP_NS   = 2000;
   localparam int PMC_FLASH_UP_CYC  =
      (PMC_FLASH_UP_NS * (PMC_CLK_HZ / 1_000_000) + 999) / 1000;

   typedef struct packed {
      logic       cpu_clk_en;
      logic       cpu_stall;
      logic       digital_on;
      logic [1:0] flash_on;
      logic       sram_a_on;
      logic       sram_b_on;
      logic       fast_osc_on;
      logic       slow_clk_sel;
   } pmc_power_t;

endpackage : pmc_pkg

// ### design/pmc_flash_timer.sv
// Flash power-up timer: counts the settle time after a start pulse.
// Assumes start is a one-cycle pulse in the system clock domain.
`timescale 1ns/100ps
module pmc_flash_timer
   import pmc_pkg::*;
#(
   parameter int CYCLES = PMC_FLASH_UP_CYC
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   wire           running = (count != '0);

   assign next_count = start_i ? CW'(CYCLES) : (running ? count - 1'b1 : count);
   assign busy_o     = running;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= '0;
         done_o <= 1'b0;
      end else begin
         count  <= next_count;
         done_o <= (count == CW'(1)) && !start_i;
      end
   end
endmodule : pmc_flash_timer

// ### design/pmc_power_mode_controller.sv
// Power mode controller: mode entry on wait-for-interrupt, wake-up sequencing.
// Assumes synchronous inputs, a strobe register port and a 10 MHz clock.
// Contract
// - Four modes run, sleep, deep sleep, coma, chosen by software register.
// - Run keeps everything powered, oscillators running, processor clock ungated.
// - Sleep gates only the processor clock; all else as in run.
// - Interrupt in sleep ungates processor clock and returns to run.
// - Deep sleep gates processor clock and powers flash off.
// - Deep sleep wake restores flash power first, then ungates processor clock.
// - Coma powers only retention registers of the digital domain.
// - Coma stops fast oscillator, selects slow clock, processor clock gated.
// - Interrupt in coma repowers flash and digital logic, enters run.
// - Coma wake keeps processor stalled until flash is properly powered.
// - Coma wake powers only flash banks enabled by flash settings.
// - Fast clock runs in run, sleep, deep sleep; off in coma.
// - Retention SRAMs powered except in coma, where each follows its setting.
// - Coma entry refused while a debugger is attached.
`timescale 1ns/100ps
module pmc_power_mode_controller
   import pmc_pkg::*;
#(
   parameter int FLASH_CYCLES = PMC_FLASH_UP_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        cpu_wfi_i,
   input  wire logic        irq_i,
   input  wire logic        dbg_attached_i,
   output pmc_power_t       power_o,
   output pmc_mode_t        mode_o
);

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SLEEP,
      ST_DEEP,
      ST_COMA,
      ST_FLASH_UP
   } pmc_state_t;

   pmc_state_t state;
   pmc_state_t next_state;
   pmc_mode_t  target_mode;
   logic       ret_a;
   logic       ret_b;
   logic [1:0] flash_en;
   logic       from_coma;
   logic       next_from_coma;
   logic       timer_start;
   logic       timer_busy;
   logic       timer_done;

   // Register decode
   wire wr_ctrl  = reg_wr_i && (reg_addr_i == PMC_OFF_CTRL);
   wire wr_flash = reg_wr_i && (reg_addr_i == PMC_OFF_FLASH);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         target_mode <= pmc_mode_t'(PMC_RST_MODE);
         ret_a       <= PMC_RST_RET;
         ret_b       <= PMC_RST_RET;
         flash_en    <= PMC_RST_FLASH;
      end else begin
         if (wr_ctrl) begin
            target_mode <= pmc_mode_t'(reg_wdata_i[PMC_CTRL_MODE_LSB +: 2]);
            ret_a       <= reg_wdata_i[PMC_CTRL_RETA_BIT];
            ret_b       <= reg_wdata_i[PMC_CTRL_RETB_BIT];
         end
         if (wr_flash) begin
            flash_en <= reg_wdata_i[1:0];
         end
      end
   end

   // Read data, one cycle after the strobe; zero elsewhere
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      unique case (reg_addr_i)
         PMC_OFF_CTRL: begin
            rd_mux[PMC_CTRL_MODE_LSB +: 2] = target_mode;
            rd_mux[PMC_CTRL_RETA_BIT]      = ret_a;
            rd_mux[PMC_CTRL_RETB_BIT]      = ret_b;
         end
         PMC_OFF_FLASH: begin
            rd_mux[1:0] = flash_en;
         end
         PMC_OFF_STATUS: begin
            rd_mux[2:0]              = 3'(state);
            rd_mux[PMC_STAT_DBG_BIT] = dbg_attached_i;
            rd_mux[PMC_STAT_STL_BIT] = timer_busy;
         end
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // Mode sequencer
   always_comb begin
      next_state     = state;
      next_from_coma = from_coma;
      timer_start    = 1'b0;
      unique case (state)
         ST_RUN: begin
            if (cpu_wfi_i && !irq_i) begin
               unique case (target_mode)
                  PMC_MODE_SLEEP: next_state = ST_SLEEP;
                  PMC_MODE_DEEP:  next_state = ST_DEEP;
                  PMC_MODE_COMA:  next_state = dbg_attached_i ? ST_SLEEP
                                                              : ST_COMA;
                  default:        next_state = ST_RUN;
               endcase
            end
         end
         ST_SLEEP: begin
            if (irq_i) next_state = ST_RUN;
         end
         ST_DEEP: begin
            if (irq_i) begin
               next_state     = ST_FLASH_UP;
               next_from_coma = 1'b0;
               timer_start    = 1'b1;
            end
         end
         ST_COMA: begin
            if (irq_i) begin
               next_state     = ST_FLASH_UP;
               next_from_coma = 1'b1;
               timer_start    = 1'b1;
            end
         end
         ST_FLASH_UP: begin
            if (timer_done) next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state     <= ST_RUN;
         from_coma <= 1'b0;
      end else begin
         state     <= next_state;
         from_coma <= next_from_coma;
      end
   end

   pmc_flash_timer #(
      .CYCLES (FLASH_CYCLES)
   ) u_flash_timer (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (timer_start),
      .busy_o    (timer_busy),
      .done_o    (timer_done)
   );

   // Power and clock controls per state
   pmc_power_t next_power;
   pmc_mode_t  next_mode;
   always_comb begin
      next_power = '{cpu_clk_en: 1'b1, cpu_stall: 1'b0, digital_on: 1'b1,
                     flash_on: 2'h3, sram_a_on: 1'b1, sram_b_on: 1'b1,
                     fast_osc_on: 1'b1, slow_clk_sel: 1'b0};
      next_mode  = PMC_MODE_RUN;
      unique case (next_state)
         ST_RUN: begin
            next_mode = PMC_MODE_RUN;
         end
         ST_SLEEP: begin
            next_power.cpu_clk_en = 1'b0;
            next_mode             = PMC_MODE_SLEEP;
         end
         ST_DEEP: begin
            next_power.cpu_clk_en = 1'b0;
            next_power.flash_on   = 2'h0;
            next_mode             = PMC_MODE_DEEP;
         end
         ST_COMA: begin
            next_power.cpu_clk_en   = 1'b0;
            next_power.digital_on   = 1'b0;
            next_power.flash_on     = 2'h0;
            next_power.sram_a_on    = ret_a;
            next_power.sram_b_on    = ret_b;
            next_power.fast_osc_on  = 1'b0;
            next_power.slow_clk_sel = 1'b1;
            next_mode               = PMC_MODE_COMA;
         end
         ST_FLASH_UP: begin
            next_power.cpu_clk_en = 1'b0;
            next_power.cpu_stall  = 1'b1;
            next_power.flash_on   = next_from_coma ? flash_en : 2'h3;
            next_mode             = next_from_coma ? PMC_MODE_COMA : PMC_MODE_DEEP;
         end
         default: next_mode = PMC_MODE_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_o <= '{cpu_clk_en: 1'b1, cpu_stall: 1'b0, digital_on: 1'b1,
                      flash_on: 2'h3, sram_a_on: 1'b1, sram_b_on: 1'b1,
                      fast_osc_on: 1'b1, slow_clk_sel: 1'b0};
         mode_o  <= PMC_MODE_RUN;
      end else begin
         power_o <= next_power;
         mode_o  <= next_mode;
      end
   end

endmodule : pmc_power_mode_controller

// ### tb/pmc_power_mode_controller_sva.sv
// Checker for the power mode controller ports.
// Assumes one clock domain and a bind onto the controller.
`timescale 1ns/100ps
module pmc_power_mode_controller_sva
   import pmc_pkg::*;
#(parameter int FLASH_CYCLES = PMC_FLASH_UP_CYC) (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        cpu_wfi_i,
   input wire logic        irq_i,
   input wire logic        dbg_attached_i,
   input wire pmc_power_t  power_o,
   input wire pmc_mode_t   mode_o
);
   logic [3:0] cfg;
   logic [1:0] fcfg;
   int         scnt;
   pmc_power_t p;
   assign p = power_o;
   // Shadows of the settings and length of the current stall
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg  <= {PMC_RST_RET, PMC_RST_RET, PMC_RST_MODE};
         fcfg <= PMC_RST_FLASH;
         scnt <= 0;
      end else begin
         scnt <= p.cpu_stall ? scnt + 1 : 0;
         if (reg_wr_i && reg_addr_i == PMC_OFF_CTRL) cfg <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == PMC_OFF_FLASH) fcfg <= reg_wdata_i[1:0];
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   mode_entry_a: assert property (
      mode_o == PMC_MODE_RUN && cpu_wfi_i && !irq_i && cfg[1:0] != 2'h0 |=> mode_o ==
      (($past(dbg_attached_i) && $past(cfg[1:0]) == 2'h3) ? 2'h1 : $past(cfg[1:0])))
      else $error("bad entry");
   run_power_a: assert property (
      mode_o == PMC_MODE_RUN |-> p.cpu_clk_en && !p.cpu_stall && p.digital_on && p.fast_osc_on
      && !p.slow_clk_sel && p.flash_on != 2'h0) else $error("run outputs wrong");
   sleep_gate_a: assert property (
      mode_o == PMC_MODE_SLEEP |-> !p.cpu_clk_en && p.digital_on && p.flash_on != 2'h0
      && p.fast_osc_on && !p.slow_clk_sel) else $error("sleep outputs wrong");
   sleep_wake_a: assert property (
      mode_o == PMC_MODE_SLEEP && irq_i |=> mode_o == PMC_MODE_RUN) else $error("no sleep wake");
   deep_power_a: assert property (
      mode_o == PMC_MODE_DEEP && !p.cpu_stall |-> p.flash_on == 2'h0 && !p.cpu_clk_en
      && p.digital_on && p.fast_osc_on) else $error("deep outputs wrong");
   flash_first_a: assert property (
      p.cpu_stall && mode_o == PMC_MODE_DEEP |-> p.flash_on == 2'h3 && !p.cpu_clk_en)
      else $error("deep wake order wrong");
   coma_power_a: assert property (
      mode_o == PMC_MODE_COMA && !p.cpu_stall |-> !p.cpu_clk_en && !p.digital_on
      && p.flash_on == 2'h0 && !p.fast_osc_on && p.slow_clk_sel) else $error("coma outputs wrong");
   stall_len_a: assert property (
      $fell(p.cpu_stall) |-> scnt == FLASH_CYCLES + 1 && mode_o == PMC_MODE_RUN)
      else $error("stall length wrong");
   flash_bank_a: assert property (
      p.cpu_stall && mode_o == PMC_MODE_COMA |-> p.flash_on == fcfg && p.digital_on)
      else $error("flash banks wrong");
   sram_ret_a: assert property (
      !p.cpu_stall |-> (mode_o == PMC_MODE_COMA) ? (p.sram_a_on == cfg[2] && p.sram_b_on == cfg[3])
      : (p.sram_a_on && p.sram_b_on)) else $error("retention power wrong");
   coma_refuse_a: assert property (
      mode_o == PMC_MODE_RUN && dbg_attached_i |=> mode_o != PMC_MODE_COMA) else $error("coma taken");
   cover property (mode_o == PMC_MODE_COMA);
   cover property ($fell(p.cpu_stall));
   cover property (mode_o == PMC_MODE_SLEEP && dbg_attached_i);
endmodule // pmc_power_mode_controller_sva

bind pmc_power_mode_controller pmc_power_mode_controller_sva #(.FLASH_CYCLES(FLASH_CYCLES)) u_sva (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .cpu_wfi_i(cpu_wfi_i), .irq_i(irq_i), .dbg_attached_i(dbg_attached_i),
   .power_o(power_o), .mode_o(mode_o));

// ### tb/pmc_cpu_model.sv
// Processor core and wake source model.
// Assumes bench commands arrive in the system clock domain.
`timescale 1ns/100ps
module pmc_cpu_model (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic sleep_req_i,
   input  wire logic wake_req_i,
   output logic      cpu_wfi_o,
   output logic      irq_o
);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_wfi_o <= 1'b0;
         irq_o     <= 1'b0;
      end else begin
         cpu_wfi_o <= sleep_req_i;
         irq_o     <= wake_req_i;
      end
   end
endmodule // pmc_cpu_model

// ### tb/pmc_power_mode_controller_bench.sv
// Bench for the power mode controller: register tasks and mode round trips.
// Assumes the core model raises wait-for-interrupt only after settings are written.
`timescale 1ns/100ps
module pmc_power_mode_controller_bench
   import pmc_pkg::*;
   ;
   localparam int FB = 3;
   localparam pmc_power_t RUN_P = '{1'b1, 1'b0, 1'b1, 2'h3, 1'b1, 1'b1, 1'b1, 1'b0};
   logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic        sleep_req = 1'b0, wake_req = 1'b0, dbg = 1'b0, cpu_wfi, irq;
   pmc_power_t  power_o, p;
   pmc_mode_t   mode_o;
   int          fails = 0, compares = 0;
   initial forever #50 clk_sys_i = ~clk_sys_i;
   pmc_power_mode_controller #(.FLASH_CYCLES(FB)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cpu_wfi_i(cpu_wfi), .irq_i(irq), .dbg_attached_i(dbg),
      .power_o(power_o), .mode_o(mode_o));
   pmc_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sleep_req_i(sleep_req),
      .wake_req_i(wake_req), .cpu_wfi_o(cpu_wfi), .irq_o(irq));
   task automatic finish_test;
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pwr(input pmc_power_t e, input pmc_mode_t m);
      compares++;
      if (power_o !== e || mode_o !== m) begin
         fails++;
         $display("[FAIL] %0t power %h mode %h", $time, power_o, mode_o);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i) reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i) reg_rd_i <= 1'b0;
      #1 chk_word(reg_rdata_o, exp);
   endtask
   // Program the mode word and pulse wait-for-interrupt once
   task automatic enter(input logic [3:0] c);
      wr(PMC_OFF_CTRL, {28'h0, c});
      @(posedge clk_sys_i) sleep_req <= 1'b1;
      @(posedge clk_sys_i) sleep_req <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask
   // Enter a mode by wait-for-interrupt, check it, wake and time the way back
   task automatic trip(input logic [3:0] c, input pmc_power_t s, input pmc_mode_t m,
                       input int up, input logic [1:0] fl);
      int n;
      enter(c);
      #1 chk_pwr(s, m);
      rd(PMC_OFF_STATUS, {27'h0, dbg, 2'h0, m});
      @(posedge clk_sys_i) wake_req <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1 if (up != 0) chk_word(32'({power_o.cpu_clk_en, power_o.cpu_stall, power_o.digital_on,
         power_o.flash_on}), {27'h0, 3'h3, fl});
      n = 0;
      while (mode_o !== PMC_MODE_RUN && n < 50) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      if (n == 50) begin
         fails++;
         $display("[FAIL] %0t no return to run", $time);
         finish_test;
      end
      chk_word(32'(n), 32'(up));
      chk_word(32'(power_o.cpu_clk_en), 32'h1);
      @(posedge clk_sys_i) wake_req <= 1'b0;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1 chk_pwr(RUN_P, PMC_MODE_RUN);
      rd(PMC_OFF_CTRL, 32'hc);
      rd(PMC_OFF_FLASH, 32'h3);
      wr(PMC_OFF_STATUS, 32'hffffffff);
      rd(PMC_OFF_STATUS, 32'h0);
      rd(4'hc, 32'h0);
      enter(4'hc);
      #1 chk_pwr(RUN_P, PMC_MODE_RUN);
      p = RUN_P;
      p.cpu_clk_en = 1'b0;
      trip(4'hd, p, PMC_MODE_SLEEP, 0, 2'h0);
      @(posedge clk_sys_i) dbg <= 1'b1;
      rd(PMC_OFF_STATUS, 32'h10);
      trip(4'hf, p, PMC_MODE_SLEEP, 0, 2'h0);
      @(posedge clk_sys_i) dbg <= 1'b0;
      p.flash_on = 2'h0;
      trip(4'he, p, PMC_MODE_DEEP, FB + 1, 2'h3);
      rd(PMC_OFF_CTRL, 32'he);
      wr(PMC_OFF_FLASH, 32'h1);
      p = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1};
      trip(4'h7, p, PMC_MODE_COMA, FB + 1, 2'h1);
      finish_test;
   end
endmodule // pmc_power_mode_controller_bench
